//--- smc_core.sv
`timescale 1ns/1ps
module smc_core #(
   parameter int INIT_COUNT = smc_pkg::INIT_CYCLES,
   parameter int BUSY_COUNT = smc_pkg::BUSY_CYCLES
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire smc_pkg::smc_host_in_type host_in,
   output smc_pkg::smc_host_out_type host_out,
   input wire logic enc_phase_a,
   input wire logic enc_phase_b,
   input wire logic index_input,
   output smc_pkg::smc_motor_type motor_out,
   output logic host_interrupt_line
);
   import smc_pkg::*;

   if (INIT_COUNT < 2 || BUSY_COUNT < 1 || BUSY_COUNT > 255) begin : g_check
      $error("smc_core: unsupported parameter value");
   end

   function automatic logic [2:0] top_bit(input logic [5:0] m);
      top_bit = 3'h0;
      for (int i = 0; i < 6; i++) begin
         if (m[i]) begin
            top_bit = 3'(i);
         end
      end
   endfunction : top_bit

   function automatic logic [15:0] sat16(input logic signed [31:0] v);
      if (v > 32'sd32767) begin
         sat16 = 16'h7FFF;
      end else if (v < -32'sd32768) begin
         sat16 = 16'h8000;
      end else begin
         sat16 = v[15:0];
      end
   endfunction : sat16

   // =====================================================================
   // Pin synchronisers
   logic [14:0] sync1, sync2, sync3, filt, filt_q;
   wire [14:0] raw = {index_input, enc_phase_b, enc_phase_a, host_in.data, host_in.sel_n,
      host_in.wr_n, host_in.rd_n, host_in.cs_n};
   wire [14:0] next_filt = (sync2 & sync3) | (filt & (sync2 ^ sync3));

   // A bit moves only when the second and third stages agree
   always_ff @(posedge sys_clk) begin
      sync1 <= raw;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= reset ? PIN_IDLE : next_filt;
      filt_q <= reset ? PIN_IDLE : filt;
   end

   // =====================================================================
   // Host port decode
   logic ready, byte_lo, wide, motor_off, moving;
   logic [7:0] hi_byte, busy_cnt;
   logic [$clog2(INIT_COUNT+1)-1:0] init_cnt;
   smc_load_type ld;
   logic [5:0] wmask;
   logic [3:0] fil_new;
   logic [2:0] trj_new, flags, mask;
   logic [15:0] fil_pend [4];
   logic [15:0] trj_pend [6];
   logic [7:0] ds_pend;
   wire [7:0] pin_data = filt[11:4];
   wire wr_fall = filt_q[2] & ~filt[2] & ~filt[0];
   wire cmd_take = wr_fall & ~filt[3] & ready;
   wire dat_take = wr_fall & filt[3] & ready;
   wire rd_act = ~filt[0] & ~filt[1];
   wire word_done = dat_take & byte_lo;
   wire [15:0] word = {hi_byte, pin_data};
   wire [2:0] widx = top_bit(wmask);
   wire [5:0] wrest = wmask & ~(6'h01 << widx);
   wire start_take = cmd_take && pin_data == CMD_START;
   wire upd_take = cmd_take && pin_data == CMD_FILT_UPD;
   wire off_req = word_done && ld == LD_TCTRL && word[TRJ_OFF];
   wire acc_ok = motor_off | ~moving;
   wire known = pin_data == CMD_START || pin_data == CMD_FILT_UPD || pin_data == CMD_WIDE
      || pin_data == CMD_MASK || pin_data == CMD_CLEAR || pin_data == CMD_FILT_LOAD
      || pin_data == CMD_TRAJ_LOAD;
   wire busy = busy_cnt != 8'h00;

   // Command and data byte pair sequencing
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ld <= LD_NONE;
         byte_lo <= 1'b0;
         hi_byte <= 8'h00;
         wmask <= 6'h00;
         fil_new <= 4'h0;
         trj_new <= 3'h0;
         ds_pend <= 8'h00;
         mask <= MASK_RESET;
         wide <= 1'b0;
      end else if (cmd_take) begin
         byte_lo <= 1'b0;
         ld <= LD_NONE;
         case (pin_data)
            CMD_MASK: ld <= LD_MASK;
            CMD_CLEAR: ld <= LD_CLEAR;
            CMD_FILT_LOAD: ld <= LD_FCTRL;
            CMD_TRAJ_LOAD: ld <= LD_TCTRL;
            CMD_WIDE: wide <= 1'b1;
            CMD_FILT_UPD: fil_new <= 4'h0;
            CMD_START: trj_new <= {trj_new[2] & ~acc_ok, 2'b00};
            default: ld <= LD_NONE;
         endcase
      end else if (dat_take && !byte_lo) begin
         hi_byte <= pin_data;
         byte_lo <= 1'b1;
      end else if (word_done) begin
         byte_lo <= 1'b0;
         ld <= LD_NONE;
         case (ld)
            LD_MASK: mask <= word[3:1];
            LD_FCTRL: begin
               ds_pend <= word[FIL_DS_LSB +: 8];
               wmask <= {2'b00, word[3:0]};
               if (word[3:0] != 4'h0) ld <= LD_FWORD;
            end
            LD_TCTRL: begin
               wmask <= {{2{word[TRJ_ACC]}}, {2{word[TRJ_VEL]}}, {2{word[TRJ_POS]}}};
               if ((word[TRJ_ACC] | word[TRJ_VEL] | word[TRJ_POS]) == 1'b1) ld <= LD_TWORD;
            end
            LD_FWORD: begin
               fil_pend[widx[1:0]] <= word;
               fil_new[widx[1:0]] <= 1'b1;
               wmask <= wrest;
               if (wrest != 6'h00) ld <= LD_FWORD;
            end
            LD_TWORD: begin
               trj_pend[widx] <= word;
               trj_new[widx[2:1]] <= 1'b1;
               wmask <= wrest;
               if (wrest != 6'h00) ld <= LD_TWORD;
            end
            default: ld <= LD_NONE;
         endcase
      end
   end

   // Busy window and power-up delay
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         busy_cnt <= 8'h00;
         init_cnt <= '0;
         ready <= 1'b0;
      end else begin
         if (cmd_take || word_done) begin
            busy_cnt <= 8'(BUSY_COUNT);
         end else if (busy) begin
            busy_cnt <= busy_cnt - 8'h01;
         end
         if (!ready) begin
            init_cnt <= init_cnt + 1'b1;
            ready <= init_cnt == ($bits(init_cnt))'(INIT_COUNT - 1);
         end
      end
   end

   // =====================================================================
   // Flags, status byte and interrupt line
   wire ev_ready = !ready && init_cnt == ($bits(init_cnt))'(INIT_COUNT - 1);
   logic ev_done;
   wire ev_idx = filt_q[14] & ~filt[14];
   wire ev_err = cmd_take & ~known;
   wire [2:0] keep = (word_done && ld == LD_CLEAR) ? word[3:1] : 3'h7;
   wire [7:0] status = ready ? {motor_off, wide, 2'b00, flags, busy} : STATUS_RESET;

   // Hardware events win over a clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         flags <= 3'h0;
         host_out <= '0;
         host_interrupt_line <= 1'b0;
      end else begin
         flags <= (flags & keep) | {ev_idx, ev_done | ev_ready, ev_err};
         host_out.data <= (rd_act & ~filt[3]) ? status : 8'h00;
         host_out.oe <= rd_act;
         host_interrupt_line <= |(flags & mask);
      end
   end

   // =====================================================================
   // Position decoder and profile generator
   logic signed [31:0] actual, target;
   logic [31:0] accel, vmax, cur_vel;
   logic [47:0] des;
   logic dir_fwd;
   logic [10:0] smp_cnt;
   wire tick = smp_cnt == 11'(SAMPLE_CYCLES - 1);
   wire q_step = (filt[12] ^ filt_q[12]) | (filt[13] ^ filt_q[13]);
   wire q_up = ~(filt_q[12] ^ filt[13]);
   wire signed [31:0] tgt_next = trj_new[0] ? {trj_pend[1], trj_pend[0]} : target;
   wire signed [31:0] base = motor_off ? actual : des[47:16];
   wire [31:0] vel_sum = cur_vel + accel;
   wire [31:0] vel_n = (vel_sum > vmax) ? vmax : vel_sum;
   wire [47:0] des_n = dir_fwd ? des + {16'h0000, vel_n} : des - {16'h0000, vel_n};
   wire passed = dir_fwd ? $signed(des_n[47:16]) >= target : $signed(des_n[47:16]) <= target;
   assign ev_done = tick & moving & passed;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         actual <= '0;
         target <= '0;
         accel <= '0;
         vmax <= '0;
         cur_vel <= '0;
         des <= '0;
         dir_fwd <= 1'b1;
         moving <= 1'b0;
         motor_off <= 1'b1;
         smp_cnt <= 11'h000;
      end else begin
         if (q_step) actual <= q_up ? actual + 32'sd1 : actual - 32'sd1;
         smp_cnt <= (tick || start_take) ? 11'h000 : smp_cnt + 11'h001;
         if (off_req) begin
            motor_off <= 1'b1;
            moving <= 1'b0;
         end else if (start_take) begin
            target <= tgt_next;
            if (trj_new[1]) vmax <= {trj_pend[3], trj_pend[2]};
            if (trj_new[2] && acc_ok) accel <= {trj_pend[5], trj_pend[4]};
            if (motor_off) begin
               des <= {actual, 16'h0000};
               cur_vel <= '0;
            end
            dir_fwd <= tgt_next >= base;
            moving <= 1'b1;
            motor_off <= 1'b0;
         end else if (tick && moving) begin
            cur_vel <= passed ? '0 : vel_n;
            des <= passed ? {target, 16'h0000} : des_n;
            moving <= ~passed;
         end
      end
   end

   // =====================================================================
   // Loop filter, one result per sample
   logic [15:0] kp, ki, kd, il, u, err_d, derr;
   logic [7:0] ds, dcnt;
   logic signed [23:0] integ;
   wire [15:0] err = sat16(des[47:16] - actual);
   wire signed [31:0] p_kp = $signed(kp) * $signed(err);
   wire signed [31:0] p_ki = $signed(ki) * $signed(integ[23:8]);
   wire signed [31:0] p_kd = $signed(kd) * $signed(derr);
   wire [31:0] ki_abs = p_ki[31] ? 32'(-p_ki) : 32'(p_ki);
   wire limited = ki_abs > {16'h0000, il};
   wire signed [31:0] il_pos = {16'h0000, il};
   wire signed [31:0] ki_use = limited ? (p_ki[31] ? -il_pos : il_pos) : p_ki;
   wire signed [31:0] u_sum = p_kp + ki_use + p_kd;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         {kp, ki, kd, il} <= '0;
         ds <= 8'h00;
         dcnt <= 8'h00;
         integ <= '0;
         err_d <= '0;
         derr <= '0;
         u <= '0;
      end else begin
         if (upd_take) begin
            if (fil_new[3]) kp <= fil_pend[3];
            if (fil_new[2]) ki <= fil_pend[2];
            if (fil_new[1]) kd <= fil_pend[1];
            if (fil_new[0]) il <= fil_pend[0];
            ds <= ds_pend;
         end
         if (motor_off) begin
            integ <= '0;
            u <= '0;
         end else if (tick) begin
            if (!(limited && err[15] == integ[23])) integ <= integ + 24'($signed(err));
            dcnt <= (dcnt >= ds) ? 8'h00 : dcnt + 8'h01;
            if (dcnt >= ds) begin
               derr <= err - err_d;
               err_d <= err;
            end
            u <= u_sum[15:0];
         end
      end
   end

   // =====================================================================
   // Motor outputs; 12-bit words alternate halves every clock
   logic [6:0] pwm_cnt;
   wire [7:0] mag_raw = u[15] ? 8'(-u[15:8]) : u[15:8];
   wire [6:0] mag7 = mag_raw[7] ? 7'h7F : mag_raw[6:0];
   wire [7:0] next_word = wide ? {2'b00, motor_out.half_sel ? u[9:4] : u[15:10]} : u[15:8];

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pwm_cnt <= 7'h00;
         motor_out <= '0;
      end else begin
         pwm_cnt <= pwm_cnt + 7'h01;
         motor_out.half_sel <= wide & ~motor_out.half_sel;
         motor_out.word <= next_word;
         motor_out.pwm_sign <= u[15];
         motor_out.pwm_mag <= pwm_cnt < mag7;
      end
   end

   // =====================================================================
   // Checks
   status_after_reset_a: assert property (@(posedge sys_clk) $fell(reset) |-> status == 8'h00)
      else $error("status not zero after reset");
   ready_status_a: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(ready) |=> (status & 8'hBE) == 8'h84)
      else $error("status not 84 when ready");
   busy_window_a: assert property (@(posedge sys_clk) disable iff (reset)
      (cmd_take || word_done) |=> status[0] [*4] ##1 !status[0])
      else $error("busy window wrong");
   status_read_a: assert property (@(posedge sys_clk) disable iff (reset)
      (rd_act && !filt[3]) |=> host_out.oe && host_out.data == $past(status))
      else $error("status read failed");
   wide_select_a: assert property (@(posedge sys_clk) disable iff (reset)
      (cmd_take && pin_data == CMD_WIDE) |=> wide ##1 motor_out.word[7:6] == 2'b00)
      else $error("wide output not selected");
   integ_limit_a: assert property (@(posedge sys_clk) disable iff (reset)
      (ki_use[31] ? 32'(-ki_use) : 32'(ki_use)) <= {16'h0000, il})
      else $error("integral term over limit");
   target_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      !$past(start_take) |-> $stable(target))
      else $error("target changed without start");
   filter_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      !$past(upd_take) |-> $stable(kp) && $stable(il))
      else $error("filter changed without update");
   accel_moving_a: assert property (@(posedge sys_clk) disable iff (reset)
      (start_take && moving && !motor_off) |=> $stable(accel))
      else $error("acceleration changed while moving");
   start_rest_a: assert property (@(posedge sys_clk) disable iff (reset)
      (start_take && motor_off && !off_req) |=> des[47:16] == $past(actual) && cur_vel == 0
      && !motor_off)
      else $error("start did not restart from rest");
endmodule : smc_core

//--- smc_pkg.sv
// What this block does
// - Commands and data move over an 8-bit port with select, read and write strobes.
// - Select, chip select and read low together return the status byte at any time.
// - An interrupt line tells the host of unmasked flagged conditions.
// - Two quadrature phases are decoded; the leading first phase means forward.
// - Parallel output is 8 bits or 12 bits sent as two 6-bit halves.
// - PWM output is a sign plus a 7-bit pulse width magnitude.
// - Status reads 0x00 after reset, then 0x84 or 0xC4 within 1.5 ms.
// - Masking all then clearing all flags turns 0x84 into 0x80.
// - Reset selects 8-bit output; the wide output command selects 12-bit.
// - Each filter load carries the derivative interval in its top byte.
// - Integral term is limited; growth of the same sign beyond it is ignored.
// - Trajectory values wait pending until the start command.
// - Filter values wait pending until the filter update command.
// - Velocity and target change while moving; acceleration does not.
// - An acceleration change applies at a start made with the motor off or the profile finished.
// - Start energises the motor; a start made with the motor off restarts from actual position at rest.
// - A new maximum velocity acts on the running profile.
// - Busy is bit 0 of the status byte.
// - Start aborts the sample in progress; output keeps the previous value.
package smc_pkg;
localparam int CLK_PERIOD_NS = 10;
localparam int INIT_TIME_NS = 1500000;
localparam int INIT_CYCLES = INIT_TIME_NS / CLK_PERIOD_NS;
localparam int SAMPLE_CYCLES = 2048;
localparam int BUSY_CYCLES = 4;
localparam logic [7:0] CMD_START = 8'h01;
localparam logic [7:0] CMD_FILT_UPD = 8'h04;
localparam logic [7:0] CMD_WIDE = 8'h05;
localparam logic [7:0] CMD_MASK = 8'h1C;
localparam logic [7:0] CMD_CLEAR = 8'h1D;
localparam logic [7:0] CMD_FILT_LOAD = 8'h1E;
localparam logic [7:0] CMD_TRAJ_LOAD = 8'h1F;
localparam logic [7:0] STATUS_RESET = 8'h00;
localparam logic [2:0] MASK_RESET = 3'h0;
localparam logic [14:0] PIN_IDLE = 15'h400F;
localparam int TRJ_OFF = 8;
localparam int TRJ_ACC = 5;
localparam int TRJ_VEL = 3;
localparam int TRJ_POS = 1;
localparam int FIL_DS_LSB = 8;
typedef struct packed {
   logic cs_n;
   logic rd_n;
   logic wr_n;
   logic sel_n;
   logic [7:0] data;
} smc_host_in_type;
typedef struct packed {
   logic [7:0] data;
   logic oe;
} smc_host_out_type;
typedef struct packed {
   logic [7:0] word;
   logic half_sel;
   logic pwm_sign;
   logic pwm_mag;
} smc_motor_type;
typedef enum logic [2:0] {LD_NONE, LD_MASK, LD_CLEAR, LD_FCTRL, LD_TCTRL, LD_FWORD, LD_TWORD}
   smc_load_type;
endpackage : smc_pkg

//--- smc_host_model.sv
`timescale 1ns/1ps
module smc_host_model (
   input wire logic sys_clk,
   output smc_pkg::smc_host_in_type host_in,
   input wire smc_pkg::smc_host_out_type host_out
);
   import smc_pkg::*;

   // ==========================================
   // Idle bus
   // Data lines start at a pattern, never at a value the device could echo
   initial begin
      host_in = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, sel_n: 1'b1, data: 8'hA5};
   end

   // ==========================================
   // Bus cycles
   // One write strobe, held two cycles so the pin filter keeps it
   task automatic put_byte(input logic is_cmd, input logic [7:0] b);
      @(negedge sys_clk);
      host_in.sel_n = ~is_cmd;
      host_in.data = b;
      host_in.cs_n = 1'b0;
      host_in.wr_n = 1'b0;
      repeat (2) @(negedge sys_clk);
      host_in.wr_n = 1'b1;
      host_in.cs_n = 1'b1;
      host_in.sel_n = 1'b1;
      host_in.data = ~b; // Released lines show the inverse, not a stale copy
      @(negedge sys_clk); // Two idle cycles, or the pin filter hides the release
   endtask : put_byte

   // Status read; bounded wait for the output enable
   task automatic read_status(output logic [7:0] s);
      int n;
      @(negedge sys_clk);
      host_in.sel_n = 1'b0;
      host_in.cs_n = 1'b0;
      host_in.rd_n = 1'b0;
      // Enable from an earlier read stays up until the filter sees the release
      repeat (4) @(posedge sys_clk);
      for (n = 0; n < 20 && host_out.oe !== 1'b1; n++) @(posedge sys_clk) #1;
      s = host_out.data;
      @(negedge sys_clk);
      host_in.cs_n = 1'b1;
      host_in.rd_n = 1'b1;
      host_in.sel_n = 1'b1;
      @(negedge sys_clk); // Two idle cycles, or the pin filter hides the release
   endtask : read_status

   // Poll until busy clears; returns the last status seen
   task automatic wait_ready(output logic [7:0] s);
      int i;
      s = 8'hFF;
      for (i = 0; i < 30 && s[0] !== 1'b0; i++) read_status(s);
   endtask : wait_ready

   // One data word, MS byte first, once busy has cleared
   task automatic send_word(input logic [15:0] wd);
      logic [7:0] s;
      wait_ready(s);
      put_byte(1'b0, wd[15:8]);
      put_byte(1'b0, wd[7:0]);
   endtask : send_word

   // Command byte, then data pairs MS byte first, busy polled before each
   task automatic send(input logic [7:0] cmd, input int nw, input logic [15:0] w0,
                       input logic [15:0] w1);
      logic [7:0] s;
      logic [15:0] w [2];
      w[0] = w0;
      w[1] = w1;
      wait_ready(s);
      put_byte(1'b1, cmd);
      for (int k = 0; k < nw; k++) begin
         send_word(w[k]);
      end
   endtask : send
endmodule : smc_host_model

//--- tb_servo_motion_controller_host_setup.sv
`timescale 1ns/1ps
module tb_servo_motion_controller_host_setup;
   import smc_pkg::*;

   // ==========================================
   // Settings and signals
   localparam int INIT_SIM = 50; // Short init count keeps the run brief
   localparam int TIME_LIMIT = 40000;
   localparam int SETTLE = 2 * SAMPLE_CYCLES + 50;
   typedef struct {
      logic [7:0] cmd;
      int nw;
      logic [15:0] w0;
      logic [15:0] w1;
      logic [7:0] exp;
      logic [7:0] care;
   } smc_row_type;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   smc_host_in_type host_in;
   smc_host_out_type host_out;
   logic enc_phase_a = 1'b0;
   logic enc_phase_b = 1'b0;
   logic index_input = 1'b1;
   smc_motor_type motor_out;
   logic host_interrupt_line;
   logic [1:0] quad = 2'h0;
   logic [7:0] st;
   logic h;
   int errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int n_hi;
   // Acceleration, velocity and target words, high word first
   logic [15:0] prof [6] = '{16'h0000, 16'h1000, 16'h0001, 16'h0000, 16'h0000, 16'h4000};
   // Mask, clear, pending filter load, trajectory load, start
   smc_row_type rows [5] = '{
      '{CMD_MASK, 1, 16'h0000, 16'h0000, 8'h84, 8'hFF},
      '{CMD_CLEAR, 1, 16'h0000, 16'h0000, 8'h80, 8'hFF},
      '{CMD_FILT_LOAD, 2, 16'h0108, 16'h0100, 8'h80, 8'hFF},
      '{CMD_TRAJ_LOAD, 1, 16'h0000, 16'h0000, 8'h80, 8'hFF},
      '{CMD_START, 0, 16'h0000, 16'h0000, 8'h00, 8'h81}
   };

   // ==========================================
   // Clock, design and far side
   always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

   smc_core #(.INIT_COUNT(INIT_SIM), .BUSY_COUNT(BUSY_CYCLES)) smc_core_i (
      .sys_clk(sys_clk),
      .reset(reset),
      .host_in(host_in),
      .host_out(host_out),
      .enc_phase_a(enc_phase_a),
      .enc_phase_b(enc_phase_b),
      .index_input(index_input),
      .motor_out(motor_out),
      .host_interrupt_line(host_interrupt_line)
   );

   smc_host_model smc_host_model_i (
      .sys_clk(sys_clk),
      .host_in(host_in),
      .host_out(host_out)
   );

   // ==========================================
   // Checking and closing
   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check8

   task automatic check1(input string what, input logic exp, input logic seen);
      check8(what, {7'h00, exp}, {7'h00, seen});
   endtask : check1

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done

   // Hang guard: the longest wait is a few filter samples
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == TIME_LIMIT) begin
         errors = errors + 1;
         test_done();
      end
   end

   // Quadrature steps, each held long enough for the pin filter
   task automatic enc_move(input int n, input bit fwd);
      for (int i = 0; i < n; i++) begin
         @(negedge sys_clk);
         quad = fwd ? quad + 2'h1 : quad - 2'h1;
         enc_phase_a = quad[0] ^ quad[1];
         enc_phase_b = quad[1];
         repeat (3) @(negedge sys_clk);
      end
   endtask : enc_move

   // ==========================================
   // Main sequence
   initial begin
      repeat (16) @(negedge sys_clk);
      reset = 1'b0;
      smc_host_model_i.read_status(st);
      check8("status after reset", STATUS_RESET, st);
      repeat (INIT_SIM + 20) @(negedge sys_clk);
      smc_host_model_i.read_status(st);
      check8("status when ready", 8'h84, st);
      check1("half select 8-bit", 1'b0, motor_out.half_sel);
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         smc_host_model_i.send(rows[i].cmd, rows[i].nw, rows[i].w0, rows[i].w1);
         smc_host_model_i.wait_ready(st);
         check8("status after command", rows[i].exp, st & rows[i].care);
      end
      check1("interrupt line", 1'b0, host_interrupt_line);
      $display("test command table done");
      // Gains stay pending until the update command
      enc_move(8, 1'b1);
      repeat (SETTLE) @(negedge sys_clk);
      check8("word before update", 8'h00, motor_out.word);
      smc_host_model_i.send(CMD_FILT_UPD, 0, 16'h0000, 16'h0000);
      repeat (SETTLE) @(negedge sys_clk);
      check1("word nonzero", 1'b1, motor_out.word != 8'h00);
      check1("sign forward", 1'b1, motor_out.pwm_sign);
      // High time over one full period: gain 256 on an error of 8 counts
      n_hi = 0;
      repeat (128) begin
         @(negedge sys_clk);
         n_hi += motor_out.pwm_mag;
      end
      check8("pwm high count", 8'h08, 8'(n_hi));
      enc_move(16, 1'b0);
      repeat (SETTLE) @(negedge sys_clk);
      check1("sign backward", 1'b0, motor_out.pwm_sign);
      $display("test encoder and filter done");
      // Busy is seen right after a take, then clears
      smc_host_model_i.put_byte(1'b1, CMD_WIDE);
      smc_host_model_i.read_status(st);
      check1("busy after take", 1'b1, st[0]);
      smc_host_model_i.wait_ready(st);
      check1("busy cleared", 1'b0, st[0]);
      check8("wide mode status", 8'h40, st & 8'h40);
      @(posedge sys_clk) #1;
      h = motor_out.half_sel;
      @(posedge sys_clk) #1;
      check1("half select toggle", 1'b1, motor_out.half_sel ^ h);
      $display("test busy and wide done");
      // Start a real move, then try a new acceleration while it runs
      smc_host_model_i.send(CMD_TRAJ_LOAD, 1, 16'h002A, 16'h0000);
      foreach (prof[i]) smc_host_model_i.send_word(prof[i]);
      smc_host_model_i.send(CMD_START, 0, 16'h0000, 16'h0000);
      smc_host_model_i.send(CMD_TRAJ_LOAD, 2, 16'h0020, 16'h0000);
      smc_host_model_i.send_word(16'h2000);
      smc_host_model_i.send(CMD_START, 0, 16'h0000, 16'h0000);
      // Motor off, then start applies the pending acceleration
      smc_host_model_i.send(CMD_TRAJ_LOAD, 1, 16'h0100, 16'h0000);
      smc_host_model_i.wait_ready(st);
      check8("motor off", 8'h80, st & 8'h80);
      smc_host_model_i.send(CMD_START, 0, 16'h0000, 16'h0000);
      smc_host_model_i.wait_ready(st);
      check8("motor on", 8'h00, st & 8'h80);
      $display("test acceleration change done");
      // Second reset in mid-run returns to 8-bit output
      @(negedge sys_clk);
      reset = 1'b1;
      repeat (12) @(negedge sys_clk);
      reset = 1'b0;
      smc_host_model_i.read_status(st);
      check8("status after second reset", STATUS_RESET, st);
      check1("half select after reset", 1'b0, motor_out.half_sel);
      repeat (INIT_SIM + 20) @(negedge sys_clk);
      smc_host_model_i.read_status(st);
      check8("status ready again", 8'h84, st);
      $display("test second reset done");
      test_done();
   end
endmodule : tb_servo_motion_controller_host_setup
